/* hw/lps_top.sv */
// Coprocessor I/O sequencer: peripheral access, wake/sleep sequencing, two-wire master.
//
// Overview of operation
// (RULE1) Register read copies field end..start of addressed register into general register zero.
// (RULE2) Fields wider than 16 bits return the sixteen bits from the start bit.
// (RULE3) Peripheral addresses are 10-bit word addresses from the always-on control base.
// (RULE4) Register write opcode 1 writes an 8-bit immediate into the field.
// (RULE5) Field bits above the eighth are written as zero.
// (RULE6) Wake timer runs only while enabled; software or program may toggle the enable.
// (RULE7) Halt puts the coprocessor to sleep and starts the wake timer.
// (RULE8) On expiry the coprocessor powers up and starts at the entry address.
// (RULE9) After reset the program waits for one expiry of sleep period zero.
// (RULE10) Sleep-select instruction chooses the period register for following sleeps.
// (RULE11) Waking after expiry takes two clock cycles.
// (RULE12) After waking, wait the clock-settle count before running.
// (RULE13) After halt, two more cycles put the coprocessor to sleep.
// (RULE14) Clock line low and high times are separately programmable.
// (RULE15) Programmable cycles separate a falling clock edge from the next data change.
// (RULE16) Programmable waits after START and before STOP.
// (RULE17) A programmable timeout aborts a transaction.
// (RULE18) Software sets master select before any transfer instruction.
// (RULE19) Eight slave address slots; each transfer selects one.
// (RULE20) Read: addr+W, index, repeated START, addr+R, one byte, NACK, STOP.
// (RULE21) Write: addr+W, index, repeated START, addr+W, data byte, STOP.
// (RULE22) Data is sampled on falling clock edges; read byte goes to register zero.
// (RULE23) Default sleep period is register zero of five.
// (RULE24) Transfer failures latch as enable-gated status bits cleared by a clear input.
`timescale 1ns/1ps
`default_nettype none
`include "lps_consts.svh"
module lps_top #(
  parameter int TW = 24,
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Wake timer control
  input wire logic slow_clk,
  input wire logic timer_en_set,
  input wire logic timer_en_clr,
  input wire logic [4:0][TW-1:0] sleep_period_regs,
  input wire logic [CW-1:0] clock_settle_wait,
  output logic wake_timer_enable,
  // Coprocessor power and start
  input wire logic [10:0] program_entry_address,
  output logic cp_powered,
  output logic cp_start,
  output logic [10:0] cp_pc,
  // Instruction port
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  output logic instr_ready,
  output logic instr_done,
  output logic [15:0] general_reg_zero,
  // Peripheral register port
  output logic [9:0] per_addr,
  output logic per_rd,
  input wire logic [31:0] per_rdata,
  output logic per_wr,
  output logic [31:0] per_wdata,
  output logic [31:0] per_wmask,
  // Two-wire configuration and events
  input wire logic master_select,
  input wire logic [CW-1:0] scl_low_period,
  input wire logic [CW-1:0] scl_high_period,
  input wire logic [CW-1:0] sda_duty,
  input wire logic [CW-1:0] start_wait,
  input wire logic [CW-1:0] stop_wait,
  input wire logic [19:0] twi_timeout,
  input wire logic [7:0][6:0] target_address_slots,
  input wire logic [2:0] evt_enable,
  input wire logic [2:0] evt_clear,
  output logic [2:0] evt_status,
  // Two-wire pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [2:0] sync_lvl;
  lps_sync #(.W(3)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({scl_i, sda_i, slow_clk}),
    .lvl(sync_lvl)
  );
  wire slow_lvl = sync_lvl[0];
  wire sda_lvl = sync_lvl[1];
  wire scl_lvl = sync_lvl[2];
  logic slow_prev_ff;

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  lps_pkg::lps_seq_t seq_ff;
  logic [15:0] seq_cnt_ff;
  logic timer_en_ff;
  logic [2:0] sleep_sel_ff;
  logic i2c_busy_ff;
  logic tw_done;
  wire busy = per_rd | per_wr | i2c_busy_ff;
  wire [3:0] op = instr_word[`LPS_F_OP];
  wire accept = instr_valid && instr_ready;
  wire do_rd = accept && op == `LPS_OP_REG_RD;
  wire do_wr = accept && op == `LPS_OP_REG_WR;
  wire do_i2c = accept && op == `LPS_OP_I2C;
  wire do_halt = accept && op == `LPS_OP_HALT;
  wire do_sleep = accept && op == `LPS_OP_SLEEP;
  wire do_other = accept && !do_rd && !do_wr && !do_i2c;
  assign instr_ready = seq_ff == lps_pkg::SEQ_RUN && !busy;
  assign instr_done = per_rd | per_wr | tw_done | do_other;

  // ----------------------------------------
  // Peripheral read and write datapath
  // ----------------------------------------
  logic [4:0] rd_lo_ff, rd_hi_ff;
  wire [4:0] i_hi = instr_word[`LPS_F_HI];
  wire [4:0] i_lo = instr_word[`LPS_F_LO];
  wire [5:0] rd_width = 6'({1'b0, rd_hi_ff} - {1'b0, rd_lo_ff}) + 6'h01;
  wire [16:0] rd_small = (17'h00001 << rd_width) - 17'h00001;
  wire [15:0] rd_mask = (rd_width > `LPS_RD_MAX_W) ? `LPS_RD_ALL : rd_small[15:0]; // RULE2
  wire [31:0] rd_shift = per_rdata >> rd_lo_ff;
  wire [15:0] rd_val = rd_shift[15:0] & rd_mask; // RULE1
  wire [32:0] wr_span = (33'h000000001 << (6'(i_hi) + 6'h01)) - (33'h000000001 << i_lo);
  wire [31:0] wr_fmask = wr_span[31:0];
  wire [31:0] wr_data = (32'(instr_word[`LPS_F_WDATA]) << i_lo) & wr_fmask; // RULE5
  wire tmr_en_hit = per_wr && per_addr == `LPS_TMR_EN_ADDR && per_wmask[`LPS_TMR_EN_BIT];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      per_addr <= '0;
      per_rd <= 1'b0;
      per_wr <= 1'b0;
      per_wdata <= '0;
      per_wmask <= '0;
      rd_lo_ff <= '0;
      rd_hi_ff <= '0;
    end else begin
      per_rd <= do_rd;
      per_wr <= do_wr; // RULE4
      if (do_rd || do_wr) begin
        per_addr <= instr_word[`LPS_F_ADDR]; // RULE3
        rd_lo_ff <= i_lo;
        rd_hi_ff <= i_hi;
        per_wdata <= wr_data;
        per_wmask <= wr_fmask;
      end
    end
  end

  // ----------------------------------------
  // Wake-up timer and sequencer
  // ----------------------------------------
  lps_tmr_if #(.TW(TW)) tmr_bus ();
  lps_wake_timer #(.TW(TW)) u_timer (
    .clk(clk),
    .rstn(rstn),
    .tif(tmr_bus.tmr)
  );
  assign tmr_bus.run = seq_ff == lps_pkg::SEQ_SLEEP && timer_en_ff; // RULE6 RULE7
  assign tmr_bus.tick = slow_lvl && !slow_prev_ff;
  assign tmr_bus.period = sleep_period_regs[sleep_sel_ff]; // RULE23
  assign wake_timer_enable = timer_en_ff;
  assign cp_powered = seq_ff != lps_pkg::SEQ_SLEEP;
  wire [15:0] seq_inc = seq_cnt_ff + 16'h0001;
  wire wake_last = seq_inc == `LPS_WAKE_CYC;
  wire settle_last = seq_inc == 16'(clock_settle_wait);
  wire settle_skip = clock_settle_wait == '0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slow_prev_ff <= 1'b1;
      timer_en_ff <= 1'b0;
      sleep_sel_ff <= '0; // RULE9
    end else begin
      slow_prev_ff <= slow_lvl;
      if (timer_en_set) begin
        timer_en_ff <= 1'b1;
      end else if (timer_en_clr) begin
        timer_en_ff <= 1'b0;
      end else if (tmr_en_hit) begin
        timer_en_ff <= per_wdata[`LPS_TMR_EN_BIT]; // RULE6
      end
      if (do_sleep && instr_word[`LPS_F_SLP_SEL] < `LPS_NUM_SLP) begin
        sleep_sel_ff <= instr_word[`LPS_F_SLP_SEL]; // RULE10
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seq_ff <= lps_pkg::SEQ_SLEEP;
      seq_cnt_ff <= '0;
      cp_start <= 1'b0;
      cp_pc <= '0;
    end else begin
      cp_start <= 1'b0;
      seq_cnt_ff <= seq_inc;
      unique case (seq_ff)
        lps_pkg::SEQ_SLEEP: begin
          seq_cnt_ff <= '0;
          if (tmr_bus.expire) begin
            seq_ff <= lps_pkg::SEQ_WAKE; // RULE8
          end
        end
        lps_pkg::SEQ_WAKE: begin
          if (wake_last) begin // RULE11
            seq_cnt_ff <= '0;
            seq_ff <= settle_skip ? lps_pkg::SEQ_RUN : lps_pkg::SEQ_SETTLE;
            cp_start <= settle_skip;
            cp_pc <= program_entry_address;
          end
        end
        lps_pkg::SEQ_SETTLE: begin
          if (settle_last) begin // RULE12
            seq_ff <= lps_pkg::SEQ_RUN;
            cp_start <= 1'b1;
            cp_pc <= program_entry_address; // RULE8
          end
        end
        lps_pkg::SEQ_RUN: begin
          seq_cnt_ff <= '0;
          if (do_halt) begin
            seq_ff <= lps_pkg::SEQ_HALT;
          end
        end
        lps_pkg::SEQ_HALT: begin
          if (wake_last) begin // RULE13
            seq_ff <= lps_pkg::SEQ_SLEEP;
          end
        end
        default: begin
          seq_ff <= lps_pkg::SEQ_SLEEP;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Two-wire master
  // ----------------------------------------
  lps_pkg::lps_tw_t tw_ff;
  logic tw_rd_ff, phase_ff, rs_ff;
  logic [1:0] byte_ix_ff;
  logic [3:0] bit_ix_ff;
  logic [7:0] sh_ff, rx_ff, sub_ff, dat_ff;
  logic [6:0] addr_ff;
  logic [CW-1:0] cnt_ff;
  logic [19:0] tot_ff;
  logic tw_done_ff, tw_nack_ff, tw_tmo_ff;
  wire [7:0] byte_tbl [4];
  assign byte_tbl[0] = {addr_ff, 1'b0};
  assign byte_tbl[1] = sub_ff;
  assign byte_tbl[2] = {addr_ff, tw_rd_ff}; // RULE20 RULE21
  assign byte_tbl[3] = tw_rd_ff ? 8'hFF : dat_ff;
  wire [CW-1:0] cnt_inc = cnt_ff + CW'(1);
  wire low_end = cnt_inc == scl_low_period; // RULE14
  wire high_end = cnt_inc == scl_high_period;
  wire at_duty = cnt_ff == sda_duty; // RULE15
  wire ack_slot = bit_ix_ff == `LPS_ACK_BIT;
  wire tx_bit = ack_slot ? 1'b1 : sh_ff[7];
  wire ack_bad = ack_slot && sda_lvl && !(tw_rd_ff && byte_ix_ff == 2'h3);
  wire tw_go = do_i2c && master_select;
  wire tw_abort = tw_ff != lps_pkg::TW_IDLE && tot_ff == twi_timeout; // RULE17
  assign tw_done = tw_done_ff | (do_i2c && !master_select); // RULE18
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tw_ff <= lps_pkg::TW_IDLE;
      tw_rd_ff <= 1'b0;
      phase_ff <= 1'b0;
      rs_ff <= 1'b0;
      byte_ix_ff <= '0;
      bit_ix_ff <= '0;
      sh_ff <= '0;
      rx_ff <= '0;
      sub_ff <= '0;
      dat_ff <= '0;
      addr_ff <= '0;
      cnt_ff <= '0;
      tot_ff <= '0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      tw_done_ff <= 1'b0;
      tw_nack_ff <= 1'b0;
      tw_tmo_ff <= 1'b0;
    end else begin
      tw_done_ff <= 1'b0;
      tw_nack_ff <= 1'b0;
      tw_tmo_ff <= 1'b0;
      cnt_ff <= cnt_inc;
      tot_ff <= (tw_ff == lps_pkg::TW_IDLE) ? '0 : tot_ff + 20'h00001;
      if (tw_abort) begin
        tw_ff <= lps_pkg::TW_IDLE;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
        tw_tmo_ff <= 1'b1;
        tw_done_ff <= 1'b1;
      end else begin
        unique case (tw_ff)
          lps_pkg::TW_IDLE: begin
            cnt_ff <= '0;
            if (tw_go) begin
              tw_ff <= lps_pkg::TW_START;
              tw_rd_ff <= !instr_word[`LPS_F_I2C_RW];
              addr_ff <= target_address_slots[instr_word[`LPS_F_I2C_SEL]]; // RULE19
              sub_ff <= instr_word[`LPS_F_I2C_SUB];
              dat_ff <= instr_word[`LPS_F_I2C_DATA];
              byte_ix_ff <= '0;
              phase_ff <= 1'b0;
            end
          end
          lps_pkg::TW_START: begin
            if (!phase_ff && high_end) begin
              sda_oe <= 1'b1;
              phase_ff <= 1'b1;
              cnt_ff <= '0;
            end else if (phase_ff && cnt_inc == start_wait) begin // RULE16
              tw_ff <= lps_pkg::TW_LOW;
              scl_oe <= 1'b1;
              rs_ff <= 1'b0;
              sh_ff <= byte_tbl[byte_ix_ff];
              bit_ix_ff <= '0;
              cnt_ff <= '0;
            end
          end
          lps_pkg::TW_LOW: begin
            if (at_duty) begin
              sda_oe <= rs_ff ? 1'b0 : !tx_bit;
            end
            if (low_end) begin
              tw_ff <= rs_ff ? lps_pkg::TW_START : lps_pkg::TW_HIGH;
              phase_ff <= 1'b0;
              scl_oe <= 1'b0;
              cnt_ff <= '0;
            end
          end
          lps_pkg::TW_HIGH: begin
            if (!scl_lvl) begin
              cnt_ff <= cnt_ff;
            end else if (high_end) begin
              scl_oe <= 1'b1;
              cnt_ff <= '0;
              if (!ack_slot) begin
                rx_ff <= {rx_ff[6:0], sda_lvl}; // RULE22
                sh_ff <= {sh_ff[6:0], 1'b1};
                bit_ix_ff <= bit_ix_ff + 4'h1;
                tw_ff <= lps_pkg::TW_LOW;
              end else if (ack_bad || byte_ix_ff == 2'h3) begin
                tw_nack_ff <= ack_bad;
                tw_ff <= lps_pkg::TW_STOP;
                phase_ff <= 1'b0;
              end else begin
                byte_ix_ff <= byte_ix_ff + 2'h1;
                rs_ff <= byte_ix_ff == 2'h1;
                sh_ff <= byte_tbl[byte_ix_ff + 2'h1];
                bit_ix_ff <= '0;
                tw_ff <= lps_pkg::TW_LOW;
              end
            end
          end
          lps_pkg::TW_STOP: begin
            if (!phase_ff) begin
              if (at_duty) begin
                sda_oe <= 1'b1;
              end
              if (low_end) begin
                scl_oe <= 1'b0;
                phase_ff <= 1'b1;
                cnt_ff <= '0;
              end
            end else if (cnt_inc == stop_wait) begin // RULE16
              sda_oe <= 1'b0;
              tw_ff <= lps_pkg::TW_IDLE;
              tw_done_ff <= 1'b1;
            end
          end
          default: begin
            tw_ff <= lps_pkg::TW_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Register zero, transfer busy and events
  // ----------------------------------------
  logic [2:0] evt_ff;
  wire [2:0] evt_hit = {tw_done_ff, tw_tmo_ff, tw_nack_ff} & evt_enable; // RULE24
  assign evt_status = evt_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      general_reg_zero <= '0;
      i2c_busy_ff <= 1'b0;
      evt_ff <= '0;
    end else begin
      evt_ff <= (evt_ff & ~evt_clear) | evt_hit;
      i2c_busy_ff <= tw_go | (i2c_busy_ff & !tw_done_ff);
      if (per_rd) begin
        general_reg_zero <= rd_val; // RULE1
      end else if (tw_done_ff && tw_rd_ff && !tw_nack_ff && !tw_tmo_ff) begin
        general_reg_zero <= {8'h00, rx_ff}; // RULE22
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_rd_field: assert property (per_rd && rd_width <= `LPS_RD_MAX_W |=>
    general_reg_zero == (16'($past(per_rdata) >> $past(rd_lo_ff)) & $past(rd_small[15:0])))
    else $error("read field mismatch"); // RULE1
  a_rd_wide: assert property (per_rd && rd_width > `LPS_RD_MAX_W |=>
    general_reg_zero == 16'($past(per_rdata) >> $past(rd_lo_ff)))
    else $error("wide read not clipped to 16 bits"); // RULE2
  a_wr_data: assert property (per_wr |-> (per_wdata & ~per_wmask) == '0 && (per_wdata >> rd_lo_ff) < 32'h00000100)
    else $error("write data outside 8-bit field"); // RULE5
  a_timer_gate: assert property (tmr_bus.expire |-> timer_en_ff && seq_ff == lps_pkg::SEQ_SLEEP)
    else $error("timer expired while disabled"); // RULE6
  a_wake_two: assert property (seq_ff == lps_pkg::SEQ_SLEEP && tmr_bus.expire |=>
    seq_ff == lps_pkg::SEQ_WAKE ##1 seq_ff == lps_pkg::SEQ_WAKE ##1 seq_ff != lps_pkg::SEQ_WAKE)
    else $error("wake did not take two cycles"); // RULE11
  a_halt_two: assert property (do_halt |=> seq_ff == lps_pkg::SEQ_HALT [*2] ##1 seq_ff == lps_pkg::SEQ_SLEEP)
    else $error("halt did not sleep after two cycles"); // RULE13
  a_entry_pc: assert property (cp_start |-> seq_ff == lps_pkg::SEQ_RUN && $past(seq_ff) != lps_pkg::SEQ_RUN)
    else $error("start pulse outside run entry"); // RULE8
  a_settle_run: assert property (seq_ff == lps_pkg::SEQ_RUN && $past(seq_ff) == lps_pkg::SEQ_SETTLE |->
    seq_cnt_ff == 16'(clock_settle_wait))
    else $error("settle wait not counted"); // RULE12
  a_nack_event: assert property (tw_nack_ff && evt_enable[`LPS_EVT_NACK] |=> evt_status[`LPS_EVT_NACK])
    else $error("nack event not latched"); // RULE24
endmodule : lps_top
`default_nettype wire

/* hw/lps_consts.svh */
// Constants for the low-power coprocessor I/O sequencer: opcodes, field positions, counts.
`ifndef LPS_CONSTS_SVH
`define LPS_CONSTS_SVH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define LPS_OP_REG_WR 4'h1
`define LPS_OP_REG_RD 4'h2
`define LPS_OP_I2C 4'h3
`define LPS_OP_SLEEP 4'h9
`define LPS_OP_HALT 4'hB
// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define LPS_F_OP 31:28
`define LPS_F_HI 27:23
`define LPS_F_LO 22:18
`define LPS_F_WDATA 17:10
`define LPS_F_ADDR 9:0
`define LPS_F_SLP_SEL 2:0
`define LPS_F_I2C_RW 27
`define LPS_F_I2C_SEL 20:18
`define LPS_F_I2C_DATA 15:8
`define LPS_F_I2C_SUB 7:0
// ----------------------------------------
// Counts, addresses and bit positions
// ----------------------------------------
`define LPS_RD_MAX_W 6'h10
`define LPS_RD_ALL 16'hFFFF
`define LPS_WAKE_CYC 16'h0002
`define LPS_NUM_SLP 3'h5
`define LPS_TMR_EN_ADDR 10'h006
`define LPS_TMR_EN_BIT 0
`define LPS_ACK_BIT 4'h8
`define LPS_EVT_NACK 0
`define LPS_EVT_TMO 1
`define LPS_EVT_DONE 2
`endif

/* hw/lps_pkg.sv */
// Types shared by the coprocessor I/O sequencer modules.
package lps_pkg;
  typedef enum logic [2:0] {
    SEQ_SLEEP = 3'b000,
    SEQ_WAKE = 3'b001,
    SEQ_SETTLE = 3'b010,
    SEQ_RUN = 3'b011,
    SEQ_HALT = 3'b100
  } lps_seq_t;
  typedef enum logic [2:0] {
    TW_IDLE = 3'b000,
    TW_START = 3'b001,
    TW_LOW = 3'b010,
    TW_HIGH = 3'b011,
    TW_STOP = 3'b100
  } lps_tw_t;
endpackage : lps_pkg

/* hw/lps_tmr_if.sv */
// Link between the sequencer and the wake-up timer.
`timescale 1ns/1ps
`default_nettype none
interface lps_tmr_if #(parameter int TW = 24);
  logic run;
  logic tick;
  logic [TW-1:0] period;
  logic expire;
  modport seq (output run, output tick, output period, input expire);
  modport tmr (input run, input tick, input period, output expire);
endinterface : lps_tmr_if
`default_nettype wire

/* hw/lps_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module lps_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Asynchronous in, filtered level out
  input wire logic [W-1:0] din,
  output logic [W-1:0] lvl
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, lvl_ff;
  wire [W-1:0] nxt_lvl = (s2_ff & s3_ff) | (lvl_ff & (s2_ff | s3_ff));
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= '1;
      s2_ff <= '1;
      s3_ff <= '1;
      lvl_ff <= '1;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end
  assign lvl = lvl_ff;
endmodule : lps_sync
`default_nettype wire

/* hw/lps_wake_timer.sv */
// Wake-up timer counting slow clock ticks up to the selected sleep period.
`timescale 1ns/1ps
`default_nettype none
module lps_wake_timer #(
  parameter int TW = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Sequencer link
  lps_tmr_if.tmr tif
);
  logic [TW-1:0] cnt_ff;
  wire [TW-1:0] cnt_inc = cnt_ff + TW'(1);
  wire hit = tif.run && tif.tick && (cnt_inc >= tif.period);
  wire [TW-1:0] nxt_cnt = !tif.run ? '0 : hit ? '0 : tif.tick ? cnt_inc : cnt_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  assign tif.expire = hit;
endmodule : lps_wake_timer
`default_nettype wire

/* test/lps_twi_slave.sv */
// Behavioural two-wire slave with one address, acking writes and answering one read byte.
`timescale 1ns/1ps
`default_nettype none
module lps_twi_slave #(
  parameter logic [6:0] ADDR = 7'h5A,
  parameter logic [7:0] RDATA = 8'hC6
) (
  // Wire levels and pull-down request
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull
);
  int bitn = 0;
  logic on = 1'b0;
  logic rd = 1'b0;
  logic rd_next = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] rx[$];
  initial sda_pull = 1'b0;
  // The first falling clock after a START is not a data bit, hence the count of minus one.
  always @(negedge sda) if (scl) begin
    on = 1'b1;
    rd = 1'b0;
    rd_next = 1'b0;
    bitn = -1;
  end
  always @(posedge sda) if (scl) begin
    on = 1'b0;
    sda_pull = 1'b0;
  end
  always @(posedge scl) if (on && bitn < 8) sh = {sh[6:0], sda};
  // Changes only while the clock is low, so no false START or STOP is made.
  always @(negedge scl) if (on) begin
    bitn = bitn + 1;
    if (bitn == 9) begin
      bitn = 0;
      rd = rd_next;
      rd_next = 1'b0;
      sda_pull = rd & ~RDATA[7];
    end else if (rd) begin
      sda_pull = (bitn < 8) && !RDATA[7-bitn];
    end else if (bitn == 8) begin
      rx.push_back(sh);
      sda_pull = (rx.size() > 1) || (sh[7:1] == ADDR);
      rd_next = (rx.size() == 3) && sh[0];
    end
  end
endmodule : lps_twi_slave
`default_nettype wire

/* test/lps_top_test.sv */
// Self-checking bench for the coprocessor I/O sequencer.
`timescale 1ns/1ps
`default_nettype none
module lps_top_test;
  logic clk = 1'b0;
  logic slow_clk = 1'b0;
  logic rstn, timer_en_set, timer_en_clr, wake_timer_enable, cp_powered, instr_valid, instr_ready;
  logic instr_done, per_wr, master_select, scl_oe, sda_oe, slv_pull;
  logic per_rd, cp_start, scl_o, sda_o;
  logic [4:0][23:0] sleep_period_regs;
  logic [15:0] clock_settle_wait, general_reg_zero, t4, t1, t3;
  logic [10:0] program_entry_address, cp_pc;
  logic [31:0] instr_word, per_rdata, per_wdata, per_wmask;
  logic [9:0] per_addr;
  logic [19:0] tmo;
  logic [7:0][6:0] slots;
  logic [2:0] evt_enable, evt_clear, evt_status;
  wire logic scl, sda;
  int failures = 0;
  int checks = 0;
  int ticks = 0;
  int cyc = 0;
  int n;
  // ----------------------------------------
  // Pins: both lines have pull-ups
  // ----------------------------------------
  assign scl = ~scl_oe;
  assign sda = ~(sda_oe | slv_pull);
  lps_top lps_top_inst (.clk, .rstn, .slow_clk, .timer_en_set, .timer_en_clr, .sleep_period_regs,
    .clock_settle_wait, .wake_timer_enable, .program_entry_address, .cp_powered, .cp_start, .cp_pc,
    .instr_valid, .instr_word, .instr_ready, .instr_done, .general_reg_zero, .per_addr, .per_rd,
    .per_rdata, .per_wr, .per_wdata, .per_wmask, .master_select, .scl_low_period(t4), .scl_high_period(t4),
    .sda_duty(t1), .start_wait(t3), .stop_wait(t3), .twi_timeout(tmo), .target_address_slots(slots),
    .evt_enable, .evt_clear, .evt_status, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe);
  lps_twi_slave lps_twi_slave_inst (.scl(scl), .sda(sda), .sda_pull(slv_pull));
  initial forever #10 clk = ~clk;
  initial forever #80 slow_clk = ~slow_clk;
  // An edge is counted only once the three-stage input filter can have handed it to the timer.
  always @(posedge slow_clk) ticks <= #80 ticks + 1;
  always @(posedge clk) if (++cyc == 60000) begin
    failures++;
    end_sim();
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : cmp
  // Some opcodes answer in the accept cycle, so done is sampled at the falling edge.
  task automatic exec(input logic [31:0] w);
    logic d;
    @(posedge clk);
    #1 instr_word = w;
    instr_valid = 1'b1;
    do @(negedge clk); while (!instr_ready);
    d = instr_done;
    @(posedge clk);
    #1 instr_valid = 1'b0;
    while (!d) begin
      @(negedge clk);
      d = instr_done;
    end
  endtask : exec
  task automatic wake(input int p);
    int k;
    k = ticks;
    while (!cp_powered) begin
      @(posedge clk);
      #1;
    end
    k = ticks - k;
    cmp("ticks", p, k);
    n = 0;
    while (!instr_ready) begin
      @(posedge clk);
      #1 n++;
    end
    cmp("wake cycles", 7, n);
    cmp("start", 1, cp_start);
    @(posedge clk);
    #1 cmp("pc", 11'h155, cp_pc);
    $display("wake after %0d ticks done", p);
  endtask : wake
  task automatic twi(input logic [31:0] w, input logic [2:0] e, input logic [2:0] m);
    lps_twi_slave_inst.rx.delete();
    exec(w);
    @(posedge clk);
    #1 cmp("events", e, evt_status & m);
    cmp("pin out", 0, {scl_o, sda_o});
    evt_clear = 3'h7;
    @(posedge clk);
    #1 evt_clear = 3'h0;
    @(posedge clk);
    #1 cmp("cleared", 0, evt_status);
  endtask : twi
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    {timer_en_set, timer_en_clr, instr_valid, master_select} = 4'h0;
    instr_word = 32'h00000000;
    {evt_clear, evt_enable} = 6'h07;
    {t4, t1, t3, tmo} = {16'h0004, 16'h0001, 16'h0003, 20'h007D0};
    sleep_period_regs = '0;
    sleep_period_regs[0] = 24'h000003;
    sleep_period_regs[2] = 24'h000005;
    clock_settle_wait = 16'h0005;
    program_entry_address = 11'h155;
    per_rdata = 32'hA5C39F17;
    slots = '0;
    slots[5] = 7'h5A;
    slots[2] = 7'h5A;
    slots[3] = 7'h11;
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (40) @(posedge clk);
    #1 cmp("asleep", 0, cp_powered);
    timer_en_set = 1'b1;
    @(posedge clk);
    #1 timer_en_set = 1'b0;
    cmp("enable", 1, wake_timer_enable);
    wake(3);
    exec({4'h2, 5'd27, 5'd4, 8'h00, 10'h123});
    cmp("addr", 10'h123, per_addr);
    cmp("rd", 1, per_rd);
    @(posedge clk);
    #1 cmp("r0 wide", 16'h39F1, general_reg_zero);
    exec({4'h2, 5'd7, 5'd4, 8'h00, 10'h3FF});
    cmp("addr", 10'h3FF, per_addr);
    @(posedge clk);
    #1 cmp("r0", 16'h0001, general_reg_zero);
    exec({4'h1, 5'd15, 5'd4, 8'hDB, 10'h040});
    cmp("wr", 1, per_wr);
    cmp("wdata", 32'h00000DB0, per_wdata & per_wmask);
    cmp("wmask", 32'h0000FFF0, per_wmask);
    exec({4'h1, 5'd0, 5'd0, 8'h00, 10'h006});
    @(posedge clk);
    #1 cmp("enable", 0, wake_timer_enable);
    timer_en_set = 1'b1;
    @(posedge clk);
    #1 timer_en_set = 1'b0;
    $display("register access done");
    master_select = 1'b1;
    twi({4'h3, 1'b1, 6'h00, 3'd5, 2'b00, 8'h96, 8'h3C}, 3'h4, 3'h7);
    cmp("wr bytes", 32'hB43CB496, {lps_twi_slave_inst.rx[0], lps_twi_slave_inst.rx[1],
      lps_twi_slave_inst.rx[2], lps_twi_slave_inst.rx[3]});
    twi({4'h3, 1'b0, 6'h00, 3'd2, 2'b00, 8'h00, 8'h11}, 3'h4, 3'h7);
    cmp("rd bytes", 24'hB411B5, {lps_twi_slave_inst.rx[0], lps_twi_slave_inst.rx[1],
      lps_twi_slave_inst.rx[2]});
    cmp("r0 twi", 16'h00C6, general_reg_zero);
    twi({4'h3, 1'b1, 6'h00, 3'd3, 2'b00, 8'h55, 8'h01}, 3'h1, 3'h1);
    tmo = 20'h00014;
    twi({4'h3, 1'b1, 6'h00, 3'd5, 2'b00, 8'h96, 8'h3C}, 3'h6, 3'h7);
    $display("two-wire transfers done");
    exec({4'h9, 25'h0000000, 3'd2});
    exec({4'hB, 28'h0000000});
    n = 0;
    while (cp_powered) begin
      @(posedge clk);
      #1 n++;
    end
    cmp("halt cycles", 2, n);
    wake(5);
    end_sim();
  end
endmodule : lps_top_test
`default_nettype wire
